//--- verilog/fla_pkg.sv
/*
 * constants and state encodings of the fault latch block.
 * assumes a single 20 MHz clock domain.
 */
// Behaviour
// [R1] new fault flashes its indicator
// [R2] flash until acknowledge; contact closed at least 100 ms
// [R3] fault gone when acknowledged: indicators off
// [R4] clear needs the same qualification interval
// [R5] fault present when acknowledged: indicators steady
// [R6] steady indicator goes off when fault gone
// [R7] new fault flashes alarm; acknowledged one stays steady
// [R8] acknowledged temperature warning off after warning delay
// [R9] sensor error over 5 points outside range
// [R10] pressure error on excess deviation from target
// [R11] temperature warning above the maximum
// [R12] mixer warning on excess position deviation
// [R13] checksum error on defective configuration
// [R14] conditions count only after persisting
// [R15] status bits 0-4 sensors, 8-10 others, 15 checksum
// [R16] temperature and mixer warnings on binary outputs
// [R17] shorter closures change nothing
// [R18] alarm flashes, steady or off by fault states
package fla_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int ACK_MIN_MS = 100;
    localparam int ACK_CYCLES = (CLK_HZ / 1000) * ACK_MIN_MS;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int FLASH_HALF_MS = 250;

    // ------------------------------------------------------------------
    // fault indices and status word layout
    // ------------------------------------------------------------------
    localparam int NSENS = 5;
    localparam int NF = 9;
    localparam int F_MAP = 5;
    localparam int F_TEMP = 6;
    localparam int F_MIX = 7;
    localparam int F_CSUM = 8;
    localparam int ST_SENS = 0;
    localparam int ST_MAP = 8;
    localparam int ST_TEMP = 9;
    localparam int ST_MIX = 10;
    localparam int ST_CSUM = 15;

    // sensor values in 0.1 % of span; range 0..1000, 5 points = 50
    localparam logic signed [15:0] SENS_LO = -16'sd50;
    localparam logic signed [15:0] SENS_HI = 16'sd1050;

    // ------------------------------------------------------------------
    // register map (byte addresses) and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_IND = 8'h04;
    localparam logic [7:0] A_IRQ_ST = 8'h08;
    localparam logic [7:0] A_IRQ_MSK = 8'h0C;
    localparam logic [7:0] A_DLY_SENS = 8'h10;
    localparam logic [7:0] A_DLY_MAP = 8'h14;
    localparam logic [7:0] A_DLY_TEMP = 8'h18;
    localparam logic [7:0] A_DLY_MIX = 8'h1C;
    localparam logic [7:0] A_MAP_LIM = 8'h20;
    localparam logic [7:0] A_TEMP_MAX = 8'h24;
    localparam logic [7:0] A_MIX_LIM = 8'h28;
    localparam logic [15:0] RST_DLY = 16'h03E8;
    localparam logic [15:0] RST_MAP_LIM = 16'h0064;
    localparam logic [15:0] RST_TEMP_MAX = 16'h0320;
    localparam logic [15:0] RST_MIX_LIM = 16'h0032;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        IND_OFF = 2'b00,
        IND_FLASH = 2'b01,
        IND_STEADY = 2'b10
    } fla_ind_e;

endpackage

//--- verilog/fla_qualify.sv
/*
 * persistence qualifier: the reported level follows the raw condition
 * only after the mismatch has lasted delay_i millisecond ticks.
 * assumes tick_i is a one-cycle pulse from the same clock.
 */
`timescale 1ns/1ps
module fla_qualify (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic tick_i,
    input wire logic raw_i,
    input wire logic [15:0] delay_i,
    output logic present_o
);
    import fla_pkg::*;

    logic [15:0] cnt_q;
    logic present_q;

    // ------------------------------------------------------------------
    // same interval for setting and clearing, so a flicker never toggles
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= 16'h0000;
            present_q <= 1'b0;
        end else if (raw_i == present_q) begin
            cnt_q <= 16'h0000; // mismatch broken, restart
        end else if (cnt_q >= delay_i) begin
            present_q <= raw_i; // [R14] [R4]
            cnt_q <= 16'h0000;
        end else if (tick_i) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign present_o = present_q;

endmodule // fla_qualify

//--- verilog/fla_ack_filter.sv
/*
 * acknowledge contact filter: two-flop synchroniser, then one pulse once
 * the contact has stayed closed for ACK_CYCLES_P clocks.
 * assumes the contact input is asynchronous, high while closed.
 */
`timescale 1ns/1ps
module fla_ack_filter #(
    parameter int ACK_CYCLES_P = fla_pkg::ACK_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic contact_i,
    output logic ack_o
);
    import fla_pkg::*;

    localparam logic [21:0] LIM = 22'(ACK_CYCLES_P - 1);

    logic sync1_q;
    logic sync2_q;
    logic [21:0] cnt_q;
    logic done_q;
    logic ack_q;

    // synchroniser
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= contact_i;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------------
    // a short closure resets the count and never pulses; one pulse per closure
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= 22'h000000;
            done_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            ack_q <= 1'b0;
            if (!sync2_q) begin
                cnt_q <= 22'h000000; // [R17]
                done_q <= 1'b0;
            end else if (!done_q && cnt_q == LIM) begin
                ack_q <= 1'b1; // [R2]
                done_q <= 1'b1;
            end else if (!done_q) begin
                cnt_q <= cnt_q + 22'h000001;
            end
        end
    end

    assign ack_o = ack_q;

endmodule // fla_ack_filter

//--- verilog/fla_top.sv
/*
 * fault latch and acknowledge: fault detection, qualification, indicator
 * state per fault, alarm summary, binary warnings, axi4-lite registers
 * and a maskable interrupt. assumes measurements come from logic on the
 * same clock; only the acknowledge contact is asynchronous.
 */
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module fla_top #(
    parameter int ACK_CYCLES_P = fla_pkg::ACK_CYCLES,
    parameter int TICK_CYCLES_P = fla_pkg::TICK_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [fla_pkg::NSENS-1:0][15:0] sensor_val_i,
    input wire logic [15:0] map_meas_i,
    input wire logic [15:0] map_target_i,
    input wire logic [15:0] intake_air_temperature_i,
    input wire logic [15:0] mixer_fb_i,
    input wire logic [15:0] mixer_cmd_i,
    input wire logic cfg_csum_bad_i,
    input wire logic ack_contact_i,
    output logic [fla_pkg::NF-1:0] fault_led_o,
    output logic sensor_error_led_o,
    output logic alarm_led_o,
    output logic intake_temp_warning_out_o,
    output logic mixer_warning_out_o,
    output logic irq_o,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import fla_pkg::*;

    localparam logic [14:0] TICK_LIM = 15'(TICK_CYCLES_P - 1);
    localparam logic [7:0] FLASH_LIM = 8'(FLASH_HALF_MS - 1);

    logic [14:0] tick_cnt_q;
    logic tick_q;
    logic [7:0] flash_cnt_q;
    logic blink_q;
    logic ack;
    logic [NF-1:0] raw;
    logic [NF-1:0] present;
    logic [NF-1:0] present_q;
    logic [NF-1:0][15:0] delay;
    logic [NF-1:0] is_flash;
    logic [NF-1:0] is_steady;
    logic [NF-1:0] led_d;
    logic [15:0] dly_sens_q;
    logic [15:0] dly_map_q;
    logic [15:0] temp_warning_delay_q;
    logic [15:0] dly_mix_q;
    logic [15:0] map_lim_q;
    logic [15:0] temp_max_q;
    logic [15:0] mix_lim_q;
    logic [NF-1:0] irq_st_q;
    logic [NF-1:0] irq_msk_q;
    logic [15:0] fault_status_word;
    logic [15:0] map_dev;
    logic [15:0] mix_dev;
    logic wr_go;
    logic wr_hit;
    logic rd_go;
    logic [31:0] rd_d;
    logic rd_hit;
    logic [NF-1:0] w1c;

    // ------------------------------------------------------------------
    // time base
    // ------------------------------------------------------------------

    // millisecond tick; a shared enable keeps everything on one clock
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tick_cnt_q <= 15'h0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TICK_LIM);
            tick_cnt_q <= (tick_cnt_q == TICK_LIM) ? 15'h0000 : tick_cnt_q + 15'h0001;
        end
    end

    // flash pattern shared by all indicators so they blink in phase
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flash_cnt_q <= 8'h00;
            blink_q <= 1'b0;
        end else if (tick_q) begin
            if (flash_cnt_q == FLASH_LIM) begin
                flash_cnt_q <= 8'h00;
                blink_q <= ~blink_q;
            end else begin
                flash_cnt_q <= flash_cnt_q + 8'h01;
            end
        end
    end

    fla_ack_filter #(
        .ACK_CYCLES_P(ACK_CYCLES_P)
    ) u_ack (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .contact_i(ack_contact_i),
        .ack_o(ack)
    );

    // ------------------------------------------------------------------
    // fault conditions
    // ------------------------------------------------------------------

    // absolute deviations; unsigned operands, so pick the larger first
    assign map_dev = (map_meas_i > map_target_i) ? map_meas_i - map_target_i
                                                 : map_target_i - map_meas_i;
    assign mix_dev = (mixer_fb_i > mixer_cmd_i) ? mixer_fb_i - mixer_cmd_i
                                                : mixer_cmd_i - mixer_fb_i;
    assign raw[F_MAP] = map_dev > map_lim_q; // [R10]
    assign raw[F_TEMP] = intake_air_temperature_i > temp_max_q; // [R11]
    assign raw[F_MIX] = mix_dev > mix_lim_q; // [R12]
    assign raw[F_CSUM] = cfg_csum_bad_i; // [R13]
    assign delay[F_MAP] = dly_map_q;
    assign delay[F_TEMP] = temp_warning_delay_q; // [R8]
    assign delay[F_MIX] = dly_mix_q;
    assign delay[F_CSUM] = 16'h0000; // checksum result is already final

    // ------------------------------------------------------------------
    // per-fault qualification and indicator state
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++) begin : g_fault
            fla_ind_e st_q;

            if (gi < NSENS) begin : g_sens
                assign raw[gi] = ($signed(sensor_val_i[gi]) < SENS_LO) ||
                                 ($signed(sensor_val_i[gi]) > SENS_HI); // [R9]
                assign delay[gi] = dly_sens_q;
            end

            fla_qualify u_q (
                .sys_clk_i(sys_clk_i),
                .sys_rst_i(sys_rst_i),
                .tick_i(tick_q),
                .raw_i(raw[gi]),
                .delay_i(delay[gi]),
                .present_o(present[gi])
            );

            // an unacknowledged fault keeps flashing even once it has gone
            always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    st_q <= IND_OFF;
                end else begin
                    case (st_q)
                        IND_OFF: begin
                            if (present[gi] && !present_q[gi]) begin
                                st_q <= IND_FLASH; // [R1]
                            end
                        end
                        IND_FLASH: begin
                            if (ack) begin
                                st_q <= present[gi] ? IND_STEADY : IND_OFF; // [R5] [R3]
                            end
                        end
                        IND_STEADY: begin
                            if (!present[gi]) begin
                                st_q <= IND_OFF; // [R6] [R8]
                            end
                        end
                        default: st_q <= IND_OFF;
                    endcase
                end
            end

            assign is_flash[gi] = (st_q == IND_FLASH);
            assign is_steady[gi] = (st_q == IND_STEADY);
            assign led_d[gi] = is_flash[gi] ? blink_q : is_steady[gi];
        end
    endgenerate

    // previous qualified level, for edge detection
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            present_q <= '0;
        end else begin
            present_q <= present;
        end
    end

    // ------------------------------------------------------------------
    // indicator and binary outputs
    // ------------------------------------------------------------------

    // registered so the pins never glitch on state decoding
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fault_led_o <= '0;
            sensor_error_led_o <= 1'b0;
            alarm_led_o <= 1'b0;
            intake_temp_warning_out_o <= 1'b0;
            mixer_warning_out_o <= 1'b0;
        end else begin
            fault_led_o <= led_d;
            sensor_error_led_o <= (|is_flash[NSENS-1:0]) ? blink_q
                                                         : |is_steady[NSENS-1:0];
            alarm_led_o <= (|is_flash) ? blink_q : |is_steady; // [R18] [R7]
            intake_temp_warning_out_o <= led_d[F_TEMP]; // [R16]
            mixer_warning_out_o <= led_d[F_MIX]; // [R16]
        end
    end

    // status word layout; unused bits read zero
    always_comb begin
        fault_status_word = 16'h0000;
        fault_status_word[ST_SENS +: NSENS] = present[NSENS-1:0]; // [R15]
        fault_status_word[ST_MAP] = present[F_MAP];
        fault_status_word[ST_TEMP] = present[F_TEMP];
        fault_status_word[ST_MIX] = present[F_MIX];
        fault_status_word[ST_CSUM] = present[F_CSUM];
    end

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------

    // address and data taken together; one write in flight at a time
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign rd_go = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_arready = rd_go;

    // the map is dense and word aligned up to the last limit register
    always_comb begin
        wr_hit = (s_axi_awaddr <= A_MIX_LIM) && (s_axi_awaddr[1:0] == 2'h0);
    end

    // write response one cycle after the handshake
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OK;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OK : RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // configuration writes honour the two low byte lanes
    function automatic logic [15:0] merge16(input logic [15:0] old_v);
        merge16[7:0] = s_axi_wstrb[0] ? s_axi_wdata[7:0] : old_v[7:0];
        merge16[15:8] = s_axi_wstrb[1] ? s_axi_wdata[15:8] : old_v[15:8];
    endfunction

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dly_sens_q <= RST_DLY;
            dly_map_q <= RST_DLY;
            temp_warning_delay_q <= RST_DLY;
            dly_mix_q <= RST_DLY;
            map_lim_q <= RST_MAP_LIM;
            temp_max_q <= RST_TEMP_MAX;
            mix_lim_q <= RST_MIX_LIM;
            irq_msk_q <= '0;
        end else if (wr_go) begin
            case (s_axi_awaddr)
                A_DLY_SENS: dly_sens_q <= merge16(dly_sens_q);
                A_DLY_MAP: dly_map_q <= merge16(dly_map_q);
                A_DLY_TEMP: temp_warning_delay_q <= merge16(temp_warning_delay_q);
                A_DLY_MIX: dly_mix_q <= merge16(dly_mix_q);
                A_MAP_LIM: map_lim_q <= merge16(map_lim_q);
                A_TEMP_MAX: temp_max_q <= merge16(temp_max_q);
                A_MIX_LIM: mix_lim_q <= merge16(mix_lim_q);
                A_IRQ_MSK: irq_msk_q <= NF'(merge16(16'(irq_msk_q)));
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // interrupt: a fault arising sets its sticky bit; set beats clear
    // ------------------------------------------------------------------
    always_comb begin
        w1c = '0;
        if (wr_go && s_axi_awaddr == A_IRQ_ST) begin
            w1c = NF'(merge16(16'h0000));
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_st_q <= '0;
        end else begin
            irq_st_q <= (irq_st_q & ~w1c) | (present & ~present_q);
        end
    end

    assign irq_o = |(irq_st_q & irq_msk_q);

    // read data registered; answer one cycle after the address
    always_comb begin
        rd_d = 32'h00000000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            A_STATUS: rd_d[15:0] = fault_status_word;
            A_IND: rd_d = {7'h00, is_steady, 7'h00, is_flash};
            A_IRQ_ST: rd_d[NF-1:0] = irq_st_q;
            A_IRQ_MSK: rd_d[NF-1:0] = irq_msk_q;
            A_DLY_SENS: rd_d[15:0] = dly_sens_q;
            A_DLY_MAP: rd_d[15:0] = dly_map_q;
            A_DLY_TEMP: rd_d[15:0] = temp_warning_delay_q;
            A_DLY_MIX: rd_d[15:0] = dly_mix_q;
            A_MAP_LIM: rd_d[15:0] = map_lim_q;
            A_TEMP_MAX: rd_d[15:0] = temp_max_q;
            A_MIX_LIM: rd_d[15:0] = mix_lim_q;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OK;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_hit ? RESP_OK : RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // fla_top

//--- bench/fla_monitor.sv
/* concurrent checks on the fault latch top ports.
   assumes one clock domain and an active-high asynchronous reset. */
`timescale 1ns/1ps
module fla_monitor (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [fla_pkg::NF-1:0] fault_led_o,
    input wire logic sensor_error_led_o,
    input wire logic alarm_led_o,
    input wire logic intake_temp_warning_out_o,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    import fla_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // two cycles of skew allowed between the per-fault and summary registers
    sequence s_all_dark;
        (fault_led_o == 9'h000) [*3];
    endsequence
    sequence s_sens_dark;
        (fault_led_o[4:0] == 5'h00) [*3];
    endsequence
    a_alarm_dark_idle: assert property (s_all_dark |-> !alarm_led_o)
        else $error("alarm lit, no fault");
    a_sensor_dark_idle: assert property (s_sens_dark |-> !sensor_error_led_o)
        else $error("sensor summary lit");
    a_temp_out_follows: assert property ($rose(fault_led_o[6]) |-> ##[0:1] intake_temp_warning_out_o)
        else $error("warning out lags");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("no write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata changed");
    a_write_busy_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_read_busy_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
endmodule // fla_monitor
bind fla_top fla_monitor u_fla_monitor (.*);

//--- bench/fla_master_model.sv
/* master control model: closes the acknowledge contact for a set count.
   assumes go_i is a one-cycle request from the bench on the same clock. */
`timescale 1ns/1ps
module fla_master_model (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic go_i,
    input wire logic [7:0] hold_i,
    output logic contact_o
);
    logic [7:0] left_q;
    // closure length chosen by the bench; short ones probe the filter
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) left_q <= 8'h00;
        else if (go_i) left_q <= hold_i;
        else if (left_q != 8'h00) left_q <= left_q - 8'h01;
    end
    assign contact_o = (left_q != 8'h00);
endmodule // fla_master_model

//--- bench/fla_top_tb.sv
/* self-checking bench of the fault latch top with shortened counts.
   assumes the partner model drives the contact and axi answers in order. */
`timescale 1ns/1ps
module fla_top_tb;
    import fla_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [NSENS-1:0][15:0] sensor_val_i = '0;
    logic [15:0] map_meas_i = 16'h0100, map_target_i = 16'h0100, intake_air_temperature_i = 16'h0050;
    logic [15:0] mixer_fb_i = 16'h0200, mixer_cmd_i = 16'h0200;
    logic cfg_csum_bad_i = 1'b0, ack_go = 1'b0, ack_contact_i;
    logic [7:0] ack_hold = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [NF-1:0] fault_led_o;
    logic sensor_error_led_o, alarm_led_o, intake_temp_warning_out_o, mixer_warning_out_o, irq_o;
    int miscompares = 0, compares = 0;
    logic [34:0] notes[$];
    always #25 sys_clk_i = ~sys_clk_i;
    fla_top #(.ACK_CYCLES_P(20), .TICK_CYCLES_P(10)) u_fla_top (.*);
    fla_master_model u_fla_master_model (.sys_clk_i, .sys_rst_i, .go_i(ack_go), .hold_i(ack_hold),
        .contact_o(ack_contact_i));
    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [34:0] seen, input logic [34:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic sig(input int w);
        return w == 0 ? s_axi_awready : w == 1 ? s_axi_bvalid : w == 2 ? s_axi_arready : s_axi_rvalid;
    endfunction
    // settle at the falling edge, so the taking edge is the next rising one
    task automatic hs(input int w);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (sig(w) !== 1'b1 && n < 50);
        if (sig(w) !== 1'b1) begin
            miscompares++;
            tally_and_finish();
        end
        @(posedge sys_clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        notes.push_back({1'b1, r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        hs(0);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        hs(1);
        s_axi_bready <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        notes.push_back({1'b0, r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        hs(2);
        s_axi_arvalid <= 1'b0;
        hs(3);
        s_axi_rready <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic ack(input logic [7:0] n);
        ack_hold <= n;
        ack_go <= 1'b1;
        @(posedge sys_clk_i);
        ack_go <= 1'b0;
        repeat (45) @(posedge sys_clk_i);
    endtask
    // answers are taken off the note queue in the order they were asked
    always @(posedge sys_clk_i) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            if (notes.size() == 0) miscompares++;
            else chk("axi answer", s_axi_bvalid ? {1'b1, s_axi_bresp, 32'h0}
                : {1'b0, s_axi_rresp, s_axi_rdata}, notes.pop_front());
        end
    end
    initial begin
        void'($urandom(89344));
        sensor_val_i[1] <= 16'd1050;
        repeat (3) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        wr(A_DLY_TEMP, 32'h5, RESP_OK);
        wr(A_DLY_SENS, 32'h5, RESP_OK);
        wr(A_TEMP_MAX, 32'h100, RESP_OK);
        wr(8'h30, 32'h1, RESP_DECERR);
        rd(8'h2C, 32'h0, RESP_DECERR);
        rd(A_DLY_MAP, {16'h0, RST_DLY}, RESP_OK);
        intake_air_temperature_i <= 16'h0101 + 16'($urandom % 64);
        repeat (100) @(posedge sys_clk_i);
        chk("irq masked", {34'h0, irq_o}, 35'h0);
        rd(A_STATUS, 32'h200, RESP_OK);
        rd(A_IND, 32'h40, RESP_OK);
        wr(A_IRQ_MSK, 32'h1FF, RESP_OK);
        chk("irq raised", {34'h0, irq_o}, 35'h1);
        ack(8'd12);
        rd(A_IND, 32'h40, RESP_OK);
        ack(8'd30);
        rd(A_IND, 32'h40_0000, RESP_OK);
        chk("temp warning out", {34'h0, intake_temp_warning_out_o}, 35'h1);
        cfg_csum_bad_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        rd(A_IND, 32'h40_0100, RESP_OK);
        intake_air_temperature_i <= 16'h0080;
        repeat (100) @(posedge sys_clk_i);
        rd(A_IND, 32'h100, RESP_OK);
        cfg_csum_bad_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        rd(A_STATUS, 32'h0, RESP_OK);
        ack(8'd30);
        rd(A_IND, 32'h0, RESP_OK);
        chk("alarm", {34'h0, alarm_led_o}, 35'h0);
        wr(A_IRQ_ST, 32'h1FF, RESP_OK);
        chk("irq cleared", {34'h0, irq_o}, 35'h0);
        sensor_val_i[1] <= 16'd1051;
        repeat (100) @(posedge sys_clk_i);
        rd(A_STATUS, 32'h2, RESP_OK);
        tally_and_finish();
    end
endmodule // fla_top_tb
